// ===== sct_pkg.sv
`default_nettype none
package sct_pkg;
  // Register indices, byte address is four times the index
  localparam int unsigned ADR_W        = 18;
  localparam logic [15:0] CFG_IDX      = 16'h1C02;
  localparam logic [15:0] TIM_IDX      = 16'h1C04;
  localparam logic [15:0] CFG_RST      = 16'h0002;
  localparam logic [15:0] TIM_RST      = 16'h7AAF;
  // Field positions
  localparam int unsigned EN_BIT       = 0;
  localparam int unsigned WID_LSB      = 1;
  localparam int unsigned INIT_BIT     = 7;
  localparam int unsigned TRAS_LSB     = 12;
  localparam int unsigned TRFC_LSB     = 8;
  localparam int unsigned WR_REC_LSB   = 6;
  localparam int unsigned PRE_PER_LSB  = 4;
  localparam int unsigned ROW_COL_LSB  = 2;
  localparam int unsigned CL_LSB       = 0;
  localparam logic [1:0]  WID_32       = 2'h2;
  // Commands as {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0]  CMD_INH      = 4'hF;
  localparam logic [3:0]  CMD_NOP      = 4'h7;
  localparam logic [3:0]  CMD_PRE      = 4'h2;
  localparam logic [3:0]  CMD_REF      = 4'h1;
  localparam logic [3:0]  CMD_MRS      = 4'h0;
  localparam int unsigned A10_BIT      = 10;
  localparam int unsigned MRS_CL_LSB   = 4;
  // Mode register set to active wait, memory clocks
  localparam logic [4:0]  MRD_CYC      = 5'h02;
  // Initialisation states
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_PRE  = 10'h002,
    ST_WRP  = 10'h004,
    ST_REF1 = 10'h008,
    ST_WRF1 = 10'h010,
    ST_REF2 = 10'h020,
    ST_WRF2 = 10'h040,
    ST_MRS  = 10'h080,
    ST_WMRD = 10'h100,
    ST_RUN  = 10'h200
  } sct_state_e;
  // Decoded timings in memory clocks
  typedef struct packed {
    logic [4:0] tras;
    logic [4:0] trfc;
    logic [2:0] write_recovery_cycles;
    logic [2:0] precharge_period_cycles;
    logic [1:0] row_to_column_delay_cycles;
    logic [1:0] cl;
  } sct_tim_s;
  // Memory command pins
  typedef struct packed {
    logic        cke;
    logic [3:0]  code;
    logic [12:0] addr;
  } sct_cmd_s;
endpackage : sct_pkg
`default_nettype wire

// ===== sct_sync.sv
`default_nettype none
module sct_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_reg;

  // Two stage synchroniser
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_reg <= '0;
      q_o    <= '0;
    end
    else
    begin
      s1_reg <= d_i;
      q_o    <= s1_reg;
    end
  end
endmodule : sct_sync
`default_nettype wire

// ===== sct_tick_timer.sv
`default_nettype none
module sct_tick_timer #(
  parameter int unsigned W = 5
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // Control
  input  wire logic         load_i,
  input  wire logic [W-1:0] val_i,
  input  wire logic         tick_i,
  // Status
  output logic      [W-1:0] cnt_o,
  output logic              zero_o
);
  // Loads a count and steps down once per rising memory clock edge, holding at zero
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cnt_o <= '0;
    else if (load_i)
      cnt_o <= val_i;
    else if (tick_i && cnt_o != '0)
      cnt_o <= cnt_o - W'(1);
  end

  assign zero_o = (cnt_o == '0);
endmodule : sct_tick_timer
`default_nettype wire

// ===== sct_ctrl.sv
`default_nettype none
module sct_ctrl (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_b_i,
  // Wishbone slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [17:0]              wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // Memory link
  input  wire logic                     memory_clock_i,
  input  wire logic [31:0]              dq_i,
  output sct_pkg::sct_cmd_s             sdram_cmd_o,
  // Access engine hooks
  input  wire logic                     rd_cmd_i,
  input  wire logic [4:0]               op_need_i,
  input  wire logic [4:0]               wr_span_i,
  output logic      [31:0]              rd_data_o,
  output logic                          rd_valid_o,
  output logic      [5:0]               eff_act_pre_o,
  output logic      [5:0]               eff_wr_pre_o,
  output sct_pkg::sct_tim_s             timing_o,
  output logic                          bus_32_o,
  output logic                          mem_ready_o
);
  logic                 en_reg;
  logic [1:0]           wid_reg;
  logic                 init_reg;
  logic [15:0]          tim_reg;
  sct_pkg::sct_state_e  st_reg;
  logic                 wb_req;
  logic                 mclk_s;
  logic                 mclk_d_reg;
  logic                 tick;
  logic [31:0]          dq_s;
  logic                 tmr_load;
  logic [4:0]           tmr_val;
  logic [4:0]           tmr_cnt;
  logic                 tmr_zero;
  logic [1:0]           rd_cnt_reg;
  sct_pkg::sct_cmd_s    cmd_next;
  logic [5:0]           wr_need;

  // Address match for one register index
  function automatic logic adr_hit(input logic [17:0] a,
                                   input logic [15:0] idx);
    adr_hit = (a == {idx, 2'b00});
  endfunction : adr_hit

  // Link clock and data pass two flops
  sct_sync #(.W(1)) u_mclk_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (memory_clock_i),
    .q_o     (mclk_s)
  );
  sct_sync #(.W(32)) u_dq_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (dq_i),
    .q_o     (dq_s)
  );

  // Rising edge of the memory clock
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      mclk_d_reg <= 1'b0;
    else
      mclk_d_reg <= mclk_s;
  end
  assign tick = mclk_s & ~mclk_d_reg;

  // Bus handshake, answer one cycle after the request
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_req;
  end

  // Read data, unmapped and reserved bits read zero
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      wb_dat_o <= '0;
    else if (wb_req && !wb_we_i)
    begin
      wb_dat_o <= '0;
      if (adr_hit(wb_adr_i, sct_pkg::CFG_IDX))
      begin
        wb_dat_o[sct_pkg::EN_BIT]          <= en_reg;
        wb_dat_o[sct_pkg::WID_LSB +: 2]    <= wid_reg;
        wb_dat_o[sct_pkg::INIT_BIT]        <= init_reg;
      end
      else if (adr_hit(wb_adr_i, sct_pkg::TIM_IDX))
        wb_dat_o[15:0] <= tim_reg;
    end
  end

  // Configuration register writes, low byte lane only
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      en_reg  <= sct_pkg::CFG_RST[sct_pkg::EN_BIT];
      wid_reg <= sct_pkg::CFG_RST[sct_pkg::WID_LSB +: 2];
    end
    else if (wb_req && wb_we_i && wb_sel_i[0] &&
             adr_hit(wb_adr_i, sct_pkg::CFG_IDX))
    begin
      en_reg  <= wb_dat_i[sct_pkg::EN_BIT];
      wid_reg <= wb_dat_i[sct_pkg::WID_LSB +: 2];
    end
  end

  // Timing register writes per byte lane
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      tim_reg <= sct_pkg::TIM_RST;
    else if (wb_req && wb_we_i && adr_hit(wb_adr_i, sct_pkg::TIM_IDX))
    begin
      if (wb_sel_i[0])
        tim_reg[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        tim_reg[15:8] <= wb_dat_i[15:8];
    end
  end

  // Decoded timings in memory clocks
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      timing_o <= '0;
    else
    begin
      timing_o.tras <= {1'b0, tim_reg[sct_pkg::TRAS_LSB +: 4]} + 5'h01;
      timing_o.trfc <= {1'b0, tim_reg[sct_pkg::TRFC_LSB +: 4]} + 5'h01;
      timing_o.write_recovery_cycles <=
        {1'b0, tim_reg[sct_pkg::WR_REC_LSB +: 2]} + 3'h1;
      timing_o.precharge_period_cycles <=
        {1'b0, tim_reg[sct_pkg::PRE_PER_LSB +: 2]} + 3'h1;
      timing_o.row_to_column_delay_cycles <=
        tim_reg[sct_pkg::ROW_COL_LSB +: 2];
      timing_o.cl   <= tim_reg[sct_pkg::CL_LSB +: 2];
    end
  end

  // Effective active to precharge spans
  assign wr_need = {4'h0, timing_o.row_to_column_delay_cycles}
                 + {3'h0, timing_o.write_recovery_cycles}
                 + {1'b0, wr_span_i};
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      eff_act_pre_o <= '0;
      eff_wr_pre_o  <= '0;
    end
    else
    begin
      eff_act_pre_o <= (op_need_i > timing_o.tras) ? {1'b0, op_need_i}
                     : {1'b0, timing_o.tras};
      eff_wr_pre_o  <= (wr_need > {1'b0, timing_o.tras}) ? wr_need
                     : {1'b0, timing_o.tras};
    end
  end

  // Status outputs
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      bus_32_o    <= 1'b0;
      mem_ready_o <= 1'b0;
    end
    else
    begin
      bus_32_o    <= (wid_reg == sct_pkg::WID_32);
      mem_ready_o <= en_reg & init_reg;
    end
  end

  // Initialisation sequence, stepped on memory clock edges
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      st_reg <= sct_pkg::ST_IDLE;
    else if (!en_reg)
      st_reg <= sct_pkg::ST_IDLE;
    else if (tick)
    begin
      case (st_reg)
        sct_pkg::ST_IDLE: st_reg <= init_reg ? sct_pkg::ST_RUN
                                             : sct_pkg::ST_PRE;
        sct_pkg::ST_PRE:  st_reg <= sct_pkg::ST_WRP;
        sct_pkg::ST_WRP:  if (tmr_zero) st_reg <= sct_pkg::ST_REF1;
        sct_pkg::ST_REF1: st_reg <= sct_pkg::ST_WRF1;
        sct_pkg::ST_WRF1: if (tmr_zero) st_reg <= sct_pkg::ST_REF2;
        sct_pkg::ST_REF2: st_reg <= sct_pkg::ST_WRF2;
        sct_pkg::ST_WRF2: if (tmr_zero) st_reg <= sct_pkg::ST_MRS;
        sct_pkg::ST_MRS:  st_reg <= sct_pkg::ST_WMRD;
        sct_pkg::ST_WMRD: if (tmr_zero) st_reg <= sct_pkg::ST_RUN;
        sct_pkg::ST_RUN:  st_reg <= sct_pkg::ST_RUN;
        default:          st_reg <= sct_pkg::ST_IDLE;
      endcase
    end
  end

  // Set once the sequence completes, kept while disabled
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      init_reg <= 1'b0;
    else if (st_reg == sct_pkg::ST_WMRD && tick && tmr_zero)
      init_reg <= 1'b1;
  end

  // Wait counts loaded as each command goes out
  always_comb
  begin
    tmr_load = tick && en_reg;
    tmr_val  = '0;
    case (st_reg)
      sct_pkg::ST_PRE:
        tmr_val = {2'b00, timing_o.precharge_period_cycles} - 5'h01;
      sct_pkg::ST_REF1: tmr_val = timing_o.trfc - 5'h01;
      sct_pkg::ST_REF2: tmr_val = timing_o.trfc - 5'h01;
      sct_pkg::ST_MRS:  tmr_val = sct_pkg::MRD_CYC - 5'h01;
      default:          tmr_load = 1'b0;
    endcase
  end

  sct_tick_timer #(.W(5)) u_wait (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .load_i  (tmr_load),
    .val_i   (tmr_val),
    .tick_i  (tick),
    .cnt_o   (tmr_cnt),
    .zero_o  (tmr_zero)
  );

  // Command chosen by the issuing state
  always_comb
  begin
    cmd_next      = '0;
    cmd_next.cke  = 1'b1;
    cmd_next.code = sct_pkg::CMD_NOP;
    case (st_reg)
      sct_pkg::ST_PRE:
      begin
        cmd_next.code                   = sct_pkg::CMD_PRE;
        cmd_next.addr[sct_pkg::A10_BIT] = 1'b1;
      end
      sct_pkg::ST_REF1,
      sct_pkg::ST_REF2: cmd_next.code = sct_pkg::CMD_REF;
      sct_pkg::ST_MRS:
      begin
        cmd_next.code = sct_pkg::CMD_MRS;
        cmd_next.addr[sct_pkg::MRS_CL_LSB +: 3] = {1'b0, timing_o.cl};
      end
      default: cmd_next.code = sct_pkg::CMD_NOP;
    endcase
  end

  // Command pins held for a whole memory clock, idle when disabled
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sdram_cmd_o      <= '0;
      sdram_cmd_o.code <= sct_pkg::CMD_INH;
    end
    else if (!en_reg)
    begin
      sdram_cmd_o      <= '0;
      sdram_cmd_o.code <= sct_pkg::CMD_INH;
    end
    else if (tick)
      sdram_cmd_o <= cmd_next;
  end

  // Read capture on the latency edge, upper half masked on 16 bit bus
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rd_cnt_reg <= '0;
      rd_data_o  <= '0;
      rd_valid_o <= 1'b0;
    end
    else
    begin
      rd_valid_o <= 1'b0;
      if (rd_cmd_i && mem_ready_o)
        rd_cnt_reg <= timing_o.cl;
      else if (tick && rd_cnt_reg != 2'h0)
      begin
        rd_cnt_reg <= rd_cnt_reg - 2'h1;
        if (rd_cnt_reg == 2'h1)
        begin
          rd_valid_o <= 1'b1;
          rd_data_o  <= bus_32_o ? dq_s : {16'h0000, dq_s[15:0]};
        end
      end
    end
  end

  // Checks
  a_width_sel: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ##1 bus_32_o == ($past(wid_reg) == sct_pkg::WID_32))
    else $error("bus width flag wrong");
  a_init_start: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(en_reg) && !init_reg |-> ##[1:40]
    sdram_cmd_o.code == sct_pkg::CMD_PRE)
    else $error("no precharge after enable");
  a_idle_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !en_reg |=> !sdram_cmd_o.cke && sdram_cmd_o.code == sct_pkg::CMD_INH)
    else $error("interface active while disabled");
  a_tras_plus: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $past(rst_b_i) |->
    timing_o.tras == {1'b0, $past(tim_reg[15:12])} + 5'h01)
    else $error("active to precharge decode wrong");
  a_need_wins: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ##1 eff_act_pre_o >= {1'b0, $past(op_need_i)} &&
    eff_act_pre_o >= {1'b0, $past(timing_o.tras)})
    else $error("effective span too short");
  a_rfc_load: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (st_reg == sct_pkg::ST_REF1) && tick && en_reg |=>
    tmr_cnt == timing_o.trfc - 5'h01)
    else $error("refresh wait not loaded");
  a_wr_rec_dec: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $past(rst_b_i) |-> timing_o.write_recovery_cycles ==
    {1'b0, $past(tim_reg[7:6])} + 3'h1)
    else $error("write recovery decode wrong");
  a_wr_span: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ##1 eff_wr_pre_o == (($past(wr_need) > {1'b0, $past(timing_o.tras)})
    ? $past(wr_need) : {1'b0, $past(timing_o.tras)}))
    else $error("write span wrong");
  a_prech_dec: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $past(rst_b_i) |-> timing_o.precharge_period_cycles ==
    {1'b0, $past(tim_reg[5:4])} + 3'h1)
    else $error("precharge decode wrong");
  a_row_col_dec: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $past(rst_b_i) |->
    timing_o.row_to_column_delay_cycles == $past(tim_reg[3:2]))
    else $error("row to column decode wrong");
  a_cas_capture: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rd_valid_o |-> $past(tick) && $past(rd_cnt_reg) == 2'h1)
    else $error("read captured off latency");
  a_init_flag: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(init_reg) |-> $past(st_reg) == sct_pkg::ST_WMRD ##1 mem_ready_o)
    else $error("init flag out of sequence");
  c_init_done: cover property (@(posedge clk_i) $rose(init_reg));
  c_read_cap: cover property (@(posedge clk_i) rd_valid_o && bus_32_o);
  c_wb_write: cover property (@(posedge clk_i) wb_ack_o && wb_we_i);
endmodule : sct_ctrl
`default_nettype wire

// ===== sct_sdram_model.sv
`default_nettype none
module sct_sdram_model (
  // Memory link
  input  wire logic              mclk_i,
  input  wire sct_pkg::sct_cmd_s cmd_i,
  input  wire logic              rd_cmd_i,
  // Read set-up from the bench
  input  wire logic [1:0]        cl_i,
  input  wire logic [31:0]       word_i,
  // Read data pins
  output logic      [31:0]       dq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned edge_cnt = 0;
  int unsigned n_log    = 0;
  int unsigned rd_edge  = 0;
  logic [3:0]  log_code [16];
  logic [12:0] log_addr [16];
  int unsigned log_edge [16];
  initial dq_o = 32'h5A5A_0F0F;
  // Count memory clock edges and log the first 16 real commands
  always @(posedge mclk_i)
  begin
    edge_cnt <= edge_cnt + 1;
    if (cmd_i.code != sct_pkg::CMD_NOP && cmd_i.code != sct_pkg::CMD_INH
        && n_log < 16)
    begin
      log_code[n_log] <= cmd_i.code;
      log_addr[n_log] <= cmd_i.addr;
      log_edge[n_log] <= edge_cnt;
      n_log           <= n_log + 1;
    end
  end
  // Read issued after edge k gives data at edge k plus latency
  always @(posedge rd_cmd_i)
    rd_edge = edge_cnt + cl_i;
  // Data lines change every clock outside the read slot
  always @(negedge mclk_i)
    dq_o <= (edge_cnt + 1 == rd_edge) ? word_i : ~dq_o;
endmodule : sct_sdram_model
`default_nettype wire

// ===== tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [17:0] CFG = 18'h07008;
  localparam logic [17:0] TIM = 18'h07010;
  localparam logic [17:0] CTL = 18'h07000;
  localparam logic [17:0] NOMAP = 18'h0700C;
  // Bench signals
  logic              clk_i   = 1'b0;
  logic              rst_b_i = 1'b0;
  logic              mclk    = 1'b0;
  logic              cyc     = 1'b0;
  logic              stb     = 1'b0;
  logic              we      = 1'b0;
  logic [17:0]       adr     = 18'h00000;
  logic [31:0]       wdat    = 32'h0;
  logic              rd_cmd  = 1'b0;
  logic [4:0]        op_need = 5'h00;
  logic [4:0]        wr_span = 5'h00;
  logic [1:0]        cl_exp  = 2'h3;
  logic [31:0]       word    = 32'h0;
  logic [31:0]       rdat;
  logic [31:0]       dq;
  logic [31:0]       wb_dat_o;
  logic              wb_ack_o;
  sct_pkg::sct_cmd_s cmd;
  logic [31:0]       rd_data_o;
  logic              rd_valid_o;
  logic [5:0]        eff_ap;
  logic [5:0]        eff_wp;
  sct_pkg::sct_tim_s tim;
  logic              bus_32_o;
  logic              mem_ready_o;
  int unsigned       fail_count = 0;
  int unsigned       checks = 0;
  int unsigned       mclk_n = 0;
  // System clock 50 ns, memory clock 400 ns at an unrelated phase
  initial forever #25 clk_i = ~clk_i;
  initial
  begin
    #13;
    forever #200 mclk = ~mclk;
  end
  always @(posedge mclk) mclk_n++;
  // Block under test and memory model
  sct_ctrl dut_u (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .memory_clock_i(mclk),
    .dq_i(dq), .sdram_cmd_o(cmd), .rd_cmd_i(rd_cmd), .op_need_i(op_need),
    .wr_span_i(wr_span), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .eff_act_pre_o(eff_ap), .eff_wr_pre_o(eff_wp), .timing_o(tim),
    .bus_32_o(bus_32_o), .mem_ready_o(mem_ready_o)
  );
  sct_sdram_model pm_u (
    .mclk_i(mclk), .cmd_i(cmd), .rd_cmd_i(rd_cmd), .cl_i(cl_exp),
    .word_i(word), .dq_o(dq)
  );
  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : check
  task automatic give_verdict();
    $display("Counts: %0d compares, %0d mismatches", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task automatic timeout(input string nm);
    $display("Error %s expected done seen timeout", nm);
    fail_count++;
    give_verdict();
  endtask : timeout
  // One classic Wishbone cycle; ack and read data taken at a rising edge
  task automatic wb(input logic w, input logic [17:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    r = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (n >= 20)
      timeout("wb_ack_o");
  endtask : wb
  task automatic wr(input logic [17:0] a, input logic [15:0] d);
    wb(1'b1, a, {16'h0000, d}, rdat);
  endtask : wr
  task automatic t_reset();
    wb(1'b0, CFG, 32'h0, rdat);
    check("cfg reset", 32'h0000_0002, rdat);
    wb(1'b0, TIM, 32'h0, rdat);
    check("tim reset", 32'h0000_7AAF, rdat);
    check("timing_o reset", {12'h000, 5'h08, 5'h0B, 3'h3, 3'h3, 2'h3, 2'h3},
          {12'h000, tim});
    check("cmd idle", 32'h0F, {27'h0, cmd.cke, cmd.code});
    wb(1'b0, NOMAP, 32'h0, rdat);
    check("unmapped read", 32'h0, rdat);
    wr(CFG, 16'h0082);
    wb(1'b0, CFG, 32'h0, rdat);
    check("init bit write", 32'h0000_0002, rdat);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_decode();
    logic [1:0]  tw, tp, tr, cl;
    logic [15:0] v;
    logic [5:0]  ew;
    @(posedge clk_i);
    op_need <= 5'h07;
    wr_span <= 5'h03;
    for (int c = 2; c < 16; c++)
    begin
      tw = 2'(c % 3 + 1);
      tp = 2'((c + 1) % 3 + 1);
      tr = (tw == 2'h1) ? 2'h3 : 2'(c % 2 + 2);
      cl = 2'(c % 2 + 2);
      v = {4'(c), 4'(c), tw, tp, tr, cl};
      wr(TIM, v);
      repeat (3) @(negedge clk_i);
      check("timing_o", {12'h0, 5'(c + 1), 5'(c + 1), 3'(tw + 1), 3'(tp + 1),
            tr, cl}, {12'h000, tim});
      check("eff_act_pre_o", (c + 1 > 7) ? c + 1 : 7, {26'h0, eff_ap});
      ew = 6'(tr + tw + 1 + 3);
      check("eff_wr_pre_o", (c + 1 > ew) ? c + 1 : ew, {26'h0, eff_wp});
      wb(1'b0, TIM, 32'h0, rdat);
      check("tim readback", {16'h0, v}, rdat);
    end
    $display("t_decode done");
  endtask : t_decode
  task automatic t_abort();
    int unsigned b, n;
    wr(CTL, 16'h0011);
    wr(TIM, 16'h329E);
    b = pm_u.n_log;
    wr(CFG, 16'h0003);
    n = 0;
    while (pm_u.n_log == b && n < 400)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 400)
      timeout("first command");
    check("first code", 32'(sct_pkg::CMD_PRE), 32'(pm_u.log_code[b]));
    // Self-refresh lies outside this block, so disable goes straight in
    wr(CFG, 16'h0002);
    repeat (2) @(negedge clk_i);
    check("disabled cmd", 32'h0F, {27'h0, cmd.cke, cmd.code});
    b = pm_u.n_log;
    repeat (40) @(negedge clk_i);
    check("commands while off", b, pm_u.n_log);
    wb(1'b0, CFG, 32'h0, rdat);
    check("init after abort", 32'h0000_0002, rdat);
    $display("t_abort done");
  endtask : t_abort
  task automatic t_init();
    int unsigned b, n;
    b = pm_u.n_log;
    wr(CFG, 16'h0005);
    n = 0;
    rdat = 32'h0;
    while (rdat[7] !== 1'b1 && n < 300)
    begin
      wb(1'b0, CFG, 32'h0, rdat);
      n++;
    end
    if (rdat[7] !== 1'b1)
      timeout("init flag");
    check("cfg after init", 32'h0000_0085, rdat);
    check("command order", {16'h0, sct_pkg::CMD_PRE, sct_pkg::CMD_REF,
          sct_pkg::CMD_REF, sct_pkg::CMD_MRS}, {16'h0, pm_u.log_code[b],
          pm_u.log_code[b + 1], pm_u.log_code[b + 2],
          pm_u.log_code[b + 3]});
    check("precharge all", 1, pm_u.log_addr[b][10]);
    check("mode latency", 2, pm_u.log_addr[b + 3][6:4]);
    check("pre gap", 3, pm_u.log_edge[b + 1] - pm_u.log_edge[b]);
    check("ref gap", 4, pm_u.log_edge[b + 2] - pm_u.log_edge[b + 1]);
    check("mrs gap", 4, pm_u.log_edge[b + 3] - pm_u.log_edge[b + 2]);
    check("ready", 3'h7, {bus_32_o, mem_ready_o, cmd.cke});
    $display("t_init done");
  endtask : t_init
  // Reads run only once the init flag has been seen set
  task automatic t_read(input logic [1:0] c, input logic [15:0] cf,
                        input logic [31:0] w, input logic [31:0] e);
    int unsigned s, n;
    wr(TIM, {12'h329, 2'h3, c});
    wr(CFG, cf);
    @(posedge clk_i);
    cl_exp <= c;
    word   <= w;
    @(posedge mclk);
    repeat (2) @(posedge clk_i);
    rd_cmd <= 1'b1;
    s = mclk_n;
    @(posedge clk_i);
    rd_cmd <= 1'b0;
    n = 0;
    while (rd_valid_o !== 1'b1 && n < 200)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 200)
      timeout("rd_valid_o");
    check("rd_data_o", e, rd_data_o);
    check("read latency", c, mclk_n - s);
    $display("t_read done");
  endtask : t_read
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    t_reset();
    t_decode();
    t_abort();
    t_init();
    t_read(2'h2, 16'h0005, 32'hCAFE_1234, 32'hCAFE_1234);
    t_read(2'h3, 16'h0003, 32'h1357_9BDF, 32'h0000_9BDF);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
